// [pkg/fdi_pkg.sv]
// Constants and carrier types for the flash disk interrupt control block.
// Assumes a 16-bit register port with byte addresses as offsets.
`default_nettype none

package fdi_pkg;

  localparam int unsigned NUM_CHANNELS = 6;
  localparam int unsigned ADDR_WIDTH   = 16;
  localparam int unsigned DATA_WIDTH   = 16;

  // Register offsets.
  localparam logic [15:0] OFFSET_INTERRUPT_CONTROL = 16'h1010;
  localparam logic [15:0] OFFSET_INTERRUPT_STATUS  = 16'h1020;

  // Field positions in the interrupt control register.
  localparam int unsigned ENABLE_LSB      = 0;
  localparam int unsigned MASK_LSB        = 8;
  localparam int unsigned EDGE_SELECT_BIT = 14;
  localparam int unsigned GATE_BIT        = 15;

  // Bits that hold storage in the control register; 7 and 6 read as zero.
  localparam logic [15:0] CONTROL_WRITE_MASK  = 16'hFF3F;
  localparam logic [15:0] CONTROL_RESET_VALUE = 16'h0000;
  localparam logic [5:0]  STATUS_RESET_VALUE  = 6'h00;
  localparam logic [15:0] READ_IDLE_VALUE     = 16'h0000;

  // Channel numbers of the interrupt sources.
  localparam int unsigned CHANNEL_FLASH_READY     = 0;
  localparam int unsigned CHANNEL_PROTECTION      = 1;
  localparam int unsigned CHANNEL_COUNT_OVERRUN   = 2;
  localparam int unsigned CHANNEL_ECC_ERROR       = 3;
  localparam int unsigned CHANNEL_REAL_TIME_CLOCK = 4;
  localparam int unsigned CHANNEL_DMA_DONE        = 5;

  // Interrupt control register layout.
  typedef struct packed {
    logic       global_request_gate;
    logic       edge_select;
    logic [5:0] mask;
    logic [1:0] reserved_zero;
    logic [5:0] enable;
  } fdi_control_t;

  // One register port access.
  typedef struct packed {
    logic [15:0] addr;
    logic        wr;
    logic        rd;
    logic [15:0] wdata;
  } fdi_reg_req_t;

  typedef enum logic {
    FDI_TRIGGER_LEVEL,
    FDI_TRIGGER_EDGE
  } fdi_trigger_t;

endpackage

`default_nettype wire

// [src/fdi_interrupt_control.sv]
// Interrupt control of the flash disk controller: control register, status
// register and the active-low interrupt request output.
// Assumes a synchronous single-cycle register port and one-cycle source strobes.
`default_nettype none

// Functional notes
// - Six channels 0-5: flash ready, protection, overrun, ECC error, clock and DMA done.
// - An enable bit at 1 (bits 5 to 0) lets its status bit latch and raise an interrupt.
// - An enable bit at 0 holds its status bit cleared whatever the source does.
// - A mask bit at 1 in bits 13 to 8 lets a set status bit assert the active-low request.
// - A mask bit at 0 keeps its status bit from asserting the request at all.
// - With bit 14 at 0 the request stays asserted until the pending interrupt is cleared.
// - With bit 14 at 1 the request pulses low and returns high.
// - Gate bit 15 at 1 permits the request, and setting it over a pending channel fires one.
// - The gate at 0 forces the request negated whatever the status and masks.
// - Control is 16-bit read/write at 1010 hex, resets to zero, and bits 7 and 6 read 0.
// - Read-only status at 1020 hex shows latched channels in bits 5 to 0 and resets to zero.
module fdi_interrupt_control (
  // Clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RESET_N,
  // Register port
  input  wire logic [15:0] REG_ADDR,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  input  wire logic [15:0] REG_WDATA,
  output var  logic [15:0] REG_RDATA,
  // Interrupt sources, one strobe per channel
  input  wire logic [5:0]  SRC_EVENT,
  // Interrupt request toward the host
  output var  logic        IRQ_N
);

  fdi_pkg::fdi_reg_req_t req_in;
  fdi_pkg::fdi_control_t control;
  fdi_pkg::fdi_trigger_t trigger;
  logic [5:0]            status;
  logic                  request;
  logic                  request_prev;
  logic                  next_irq_n;

  assign req_in = '{addr: REG_ADDR, wr: REG_WR, rd: REG_RD, wdata: REG_WDATA};

  function automatic logic hits(input logic [15:0] addr, input logic [15:0] offset);
    hits = (addr == offset);
  endfunction

  // Control register; reserved bits never store.
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      control <= fdi_pkg::fdi_control_t'(fdi_pkg::CONTROL_RESET_VALUE);
    end else if (req_in.wr && hits(req_in.addr, fdi_pkg::OFFSET_INTERRUPT_CONTROL)) begin
      control <= fdi_pkg::fdi_control_t'(req_in.wdata & fdi_pkg::CONTROL_WRITE_MASK);
    end
  end

  // Six sticky channels, in source order 0 to 5.
  fdi_status_latch u_status (
    .clk          (CORE_CLK),
    .reset_n      (RESET_N),
    .enable       (control.enable),
    .event_strobe (SRC_EVENT),
    .status       (status)
  );

  // Read data is registered and holds until the next read; unmapped reads return zero.
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      REG_RDATA <= fdi_pkg::READ_IDLE_VALUE;
    end else if (req_in.rd) begin
      if (hits(req_in.addr, fdi_pkg::OFFSET_INTERRUPT_CONTROL)) begin
        REG_RDATA <= 16'(control);
      end else if (hits(req_in.addr, fdi_pkg::OFFSET_INTERRUPT_STATUS)) begin
        REG_RDATA <= {10'h000, status};
      end else begin
        REG_RDATA <= fdi_pkg::READ_IDLE_VALUE;
      end
    end
  end

  assign trigger = control.edge_select ? fdi_pkg::FDI_TRIGGER_EDGE : fdi_pkg::FDI_TRIGGER_LEVEL;
  assign request = control.global_request_gate &&
                   (|(status & control.mask));

  // Request level of the previous cycle, so edge mode fires only when the request rises.
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      request_prev <= 1'b0;
    end else begin
      request_prev <= request;
    end
  end

  // Edge mode turns each rise of the request into a single low clock.
  always_comb begin
    unique case (trigger)
      fdi_pkg::FDI_TRIGGER_LEVEL: next_irq_n = !request;
      fdi_pkg::FDI_TRIGGER_EDGE:  next_irq_n = !(request && !request_prev);
    endcase
  end

  // A pending channel met by a newly set gate makes a new request, so it fires at once.
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      IRQ_N <= 1'b1;
    end else begin
      IRQ_N <= next_irq_n;
    end
  end

  property p_gate_off;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      !control.global_request_gate |=> IRQ_N;
  endproperty
  a_gate_off: assert property (p_gate_off)
    else $error("Request asserted with the global gate off.");

  property p_level_hold;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      (control.global_request_gate && !control.edge_select && (|(status & control.mask)))
        |=> !IRQ_N;
  endproperty
  a_level_hold: assert property (p_level_hold)
    else $error("Level mode request not asserted for a masked-in pending channel.");

  property p_mask_blocks;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      ((status & control.mask) == 6'h00) |=> IRQ_N;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks)
    else $error("Request asserted with no masked-in status bit.");

  property p_edge_pulse_width;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      (control.edge_select && !IRQ_N) |=> IRQ_N;
  endproperty
  a_edge_pulse_width: assert property (p_edge_pulse_width)
    else $error("Edge mode pulse longer than one clock.");

  property p_edge_new_request;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      (control.edge_select && request && !request_prev) |=> !IRQ_N;
  endproperty
  a_edge_new_request: assert property (p_edge_new_request)
    else $error("Edge mode missed the pulse for a new request.");

  property p_gate_rise;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      ($rose(control.global_request_gate) && (|(status & control.mask))) |=> !IRQ_N;
  endproperty
  a_gate_rise: assert property (p_gate_rise)
    else $error("Setting the gate with a pending channel gave no request.");

  property p_read_control;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      (REG_RD && REG_ADDR == fdi_pkg::OFFSET_INTERRUPT_CONTROL)
        |=> (REG_RDATA == 16'($past(control))) && (REG_RDATA[7:6] == 2'h0);
  endproperty
  a_read_control: assert property (p_read_control)
    else $error("Control register read back wrong.");

  property p_read_status;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      (REG_RD && REG_ADDR == fdi_pkg::OFFSET_INTERRUPT_STATUS)
        |=> REG_RDATA == {10'h000, $past(status)};
  endproperty
  a_read_status: assert property (p_read_status)
    else $error("Status register read back wrong.");

  property p_mask_passes;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      (control.global_request_gate && (status[0] && control.mask[0]) && !control.edge_select)
        |=> !IRQ_N;
  endproperty
  a_mask_passes: assert property (p_mask_passes)
    else $error("Masked-in channel 0 did not assert the request.");

  property p_edge_no_repeat;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      (control.edge_select && request && request_prev) |=> IRQ_N;
  endproperty
  a_edge_no_repeat: assert property (p_edge_no_repeat)
    else $error("Edge mode pulsed again for a request already standing.");

  // Register port checks: stored bits, unmapped reads and how long read data stands.
  property p_write_control;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      (REG_WR && hits(REG_ADDR, fdi_pkg::OFFSET_INTERRUPT_CONTROL))
        |=> 16'(control) == ($past(REG_WDATA) & fdi_pkg::CONTROL_WRITE_MASK);
  endproperty
  a_write_control: assert property (p_write_control)
    else $error("Control register write did not store the writable bits.");

  property p_reserved_zero;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      REG_WR |=> control.reserved_zero == 2'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("Reserved control bits stored a one.");

  property p_unmapped_read;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      (REG_RD && !hits(REG_ADDR, fdi_pkg::OFFSET_INTERRUPT_CONTROL)
        && !hits(REG_ADDR, fdi_pkg::OFFSET_INTERRUPT_STATUS))
        |=> REG_RDATA == fdi_pkg::READ_IDLE_VALUE;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("Read of an unmapped offset returned nonzero data.");

  property p_rdata_hold;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      !REG_RD |=> $stable(REG_RDATA);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("Read data changed without a read.");

  // The first edge out of reset must see the request negated and the control, status and read data registers at their reset values.
  property p_reset_idle;
    @(posedge CORE_CLK)
      $rose(RESET_N) |-> IRQ_N && (REG_RDATA == fdi_pkg::READ_IDLE_VALUE)
        && (16'(control) == fdi_pkg::CONTROL_RESET_VALUE)
        && (status == fdi_pkg::STATUS_RESET_VALUE);
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("Registers or request not idle after reset.");

endmodule

`default_nettype wire

// [src/fdi_status_latch.sv]
// Six-channel sticky status latch of the interrupt control block.
// Assumes one-cycle event strobes synchronous to CORE_CLK.
`default_nettype none

module fdi_status_latch (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Control and sources
  input  wire logic [5:0] enable,
  input  wire logic [5:0] event_strobe,
  // Latched state
  output var  logic [5:0] status
);

  genvar ch;
  generate
    for (ch = 0; ch < 6; ch++) begin : g_channel
      // A cleared enable holds the bit clear; otherwise an event sets it and it sticks.
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          status[ch] <= fdi_pkg::STATUS_RESET_VALUE[ch];
        end else if (!enable[ch]) begin
          status[ch] <= 1'b0;
        end else begin
          status[ch] <= status[ch] | event_strobe[ch];
        end
      end
    end
  endgenerate

  property p_disabled_clear;
    @(posedge clk) disable iff (!reset_n)
      1'b1 |=> (status & ~$past(enable)) == 6'h00;
  endproperty
  a_disabled_clear: assert property (p_disabled_clear)
    else $error("Status bit set while its enable was low.");

  property p_event_latch;
    @(posedge clk) disable iff (!reset_n)
      (|(event_strobe & enable)) |=>
        ((status & $past(event_strobe) & $past(enable)) ==
         ($past(event_strobe) & $past(enable)));
  endproperty
  a_event_latch: assert property (p_event_latch)
    else $error("Enabled event was not latched into status.");

  property p_sticky;
    @(posedge clk) disable iff (!reset_n)
      (status[0] && enable[0]) |=> status[0] [*1];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("Status bit dropped while its enable stayed high.");

endmodule

`default_nettype wire

// [tb/fdi_host_model.sv]
// Host side of the interrupt request line: counts falling edges and low cycles.
// Assumes IRQ_N is registered on the rising edge of the shared clock.
`default_nettype none

module fdi_host_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Request from the device
  input  wire logic       irq_n,
  // Observed activity
  output var  logic [7:0] pulses,
  output var  logic [7:0] low_cycles
);
  timeunit 1ns;
  timeprecision 1ps;

  logic prev_n;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prev_n     <= 1'b1;
      pulses     <= 8'h00;
      low_cycles <= 8'h00;
    end else begin
      prev_n <= irq_n;
      if (prev_n && !irq_n) begin
        pulses <= pulses + 8'h01;
      end
      if (!irq_n) begin
        low_cycles <= low_cycles + 8'h01;
      end
    end
  end
endmodule

`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench of the interrupt control block with a host model.
// Assumes inputs are driven at the falling edge of a 250 MHz clock.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [15:0] ca = fdi_pkg::OFFSET_INTERRUPT_CONTROL;
  localparam logic [15:0] sa = fdi_pkg::OFFSET_INTERRUPT_STATUS;

  logic        core_clk = 1'b0;
  logic        reset_n, reg_wr, reg_rd, irq_n;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, ctrl;
  logic [5:0]  src_event, st;
  logic [7:0]  pulses, low_cycles, p0, l0;
  logic [31:0] lfsr;
  int          n_fail, num_checks;

  always #2 core_clk = ~core_clk;

  fdi_interrupt_control fdi_interrupt_control_i (
    .CORE_CLK(core_clk), .RESET_N(reset_n), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
    .SRC_EVENT(src_event), .IRQ_N(irq_n));

  fdi_host_model fdi_host_model_i (
    .clk(core_clk), .reset_n(reset_n), .irq_n(irq_n), .pulses(pulses),
    .low_cycles(low_cycles));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic exp_irq_n(input logic [15:0] c, input logic [5:0] s);
    return !(c[fdi_pkg::GATE_BIT] && |(s & c[13:8]));
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
    if (a == ca) begin
      ctrl = d & fdi_pkg::CONTROL_WRITE_MASK;
      st = st & ctrl[5:0];
    end
    @(negedge core_clk);
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    check(reg_rdata, exp);
    @(negedge core_clk);
  endtask

  task automatic ev(input logic [5:0] e);
    src_event = e;
    @(negedge core_clk);
    src_event = 6'h00;
    st = st | (e & ctrl[5:0]);
    @(negedge core_clk);
  endtask

  task automatic chk_irq();
    repeat (3) @(negedge core_clk);
    check({15'h0000, irq_n}, {15'h0000, exp_irq_n(ctrl, st)});
  endtask

  task automatic summarize();
    if (n_fail == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // The tests take about 225 cycles; the limit allows more than ten times that.
  initial begin
    #20000;
    n_fail++;
    summarize();
  end

  initial begin
    {reset_n, reg_wr, reg_rd, reg_addr, reg_wdata, src_event} = '0;
    {ctrl, st, n_fail, num_checks} = '0;
    lfsr = 32'h748D;
    repeat (5) @(negedge core_clk);
    reset_n = 1'b1;
    rd(ca, fdi_pkg::CONTROL_RESET_VALUE);
    rd(sa, {10'h000, fdi_pkg::STATUS_RESET_VALUE});
    check({15'h0000, irq_n}, 16'h0001);
    repeat (8) begin
      lfsr = lfsr_next(lfsr);
      wr(ca, lfsr[15:0] & 16'h7FFF);
      rd(ca, ctrl);
    end
    rd(16'h1012, fdi_pkg::READ_IDLE_VALUE);
    wr(sa, 16'hFFFF);
    rd(sa, {10'h000, st});
    for (int i = 0; i < 6; i++) begin
      wr(ca, 16'h8000 | (16'h0101 << i));
      lfsr = lfsr_next(lfsr);
      ev(lfsr[5:0] | (6'h01 << i));
      rd(sa, {10'h000, st});
      chk_irq();
      chk_irq();
      wr(ca, ctrl & 16'hFFC0);
      rd(sa, 16'h0000);
      chk_irq();
      wr(ca, ctrl | (16'h0001 << i));
    end
    wr(ca, 16'h803F);
    ev(6'h3F);
    rd(sa, 16'h003F);
    chk_irq();
    wr(ca, 16'h3F3F);
    chk_irq();
    wr(ca, 16'hBF3F);
    chk_irq();
    wr(ca, 16'h0000);
    wr(ca, 16'hFF3F);
    p0 = pulses;
    l0 = low_cycles;
    ev(6'h01);
    repeat (3) @(negedge core_clk);
    ev(6'h02);
    repeat (3) @(negedge core_clk);
    wr(ca, 16'hFF00);
    wr(ca, 16'hFF3F);
    ev(6'h20);
    repeat (4) @(negedge core_clk);
    check({8'h00, pulses - p0}, 16'h0002);
    check({8'h00, low_cycles - l0}, 16'h0002);
    check({15'h0000, irq_n}, 16'h0001);
    reset_n = 1'b0;
    repeat (2) @(negedge core_clk);
    reset_n = 1'b1;
    {ctrl, st} = '0;
    rd(ca, fdi_pkg::CONTROL_RESET_VALUE);
    rd(sa, {10'h000, fdi_pkg::STATUS_RESET_VALUE});
    chk_irq();
    summarize();
  end
endmodule

`default_nettype wire
